// ==== tb/ssp_checker_assertions.sv ====
// port-level assertions for the serial port top
`timescale 1ns/10ps
module ssp_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic shared_port_pin_o,
  input wire logic shared_port_pin_oe,
  input wire logic port_out,
  input wire logic port_oe,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic sel_q;
  logic ie_q;
  wire acc = psel && penable;
  wire bad = paddr > 8'h18;
  wire ok = !bad && paddr[1:0] == 2'b00;
  // shadows of pin select and irq enable, taken at the write edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sel_q <= 1'b0;
    else if (acc && pwrite && paddr == 8'h0c)
      sel_q <= pwdata[0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ie_q <= 1'b0;
    else if (acc && pwrite && paddr == 8'h08)
      ie_q <= pwdata[1];
  end
  a_ready_always: assert property (psel |-> pready)
    else $error("pready low");
  a_mapped_no_err: assert property (acc && ok |-> !pslverr)
    else $error("error on mapped address");
  a_unmapped_err: assert property (acc && bad |-> pslverr)
    else $error("no error on unmapped address");
  a_unmapped_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_read_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_pin_port: assert property (!sel_q |-> {shared_port_pin_o, shared_port_pin_oe}
    == {port_out, port_oe}) else $error("pin not port line");
  a_pin_serial_oe: assert property (sel_q |-> shared_port_pin_oe)
    else $error("pin not driven");
  a_irq_masked: assert property (!ie_q && !$past(ie_q) |-> !irq)
    else $error("irq while disabled");
  c_irq: cover property ($rose(irq));
  c_bad: cover property (acc && bad);
  c_sel: cover property (sel_q && acc);
endmodule
bind ssp_top ssp_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .shared_port_pin_o, .shared_port_pin_oe,
  .port_out, .port_oe, .irq);

// ==== tb/ssp_peer.sv ====
// behavioural serial peripheral that answers the port's master frames
`timescale 1ns/10ps
module ssp_peer (
  input wire logic sclk_q,
  input wire logic load,
  input wire logic [7:0] tx_byte,
  output logic serial_in
);
  logic [7:0] sh_q;
  // changes on the falling shift clock so the rising sample sees settled data
  // bits past the byte toggle, so a late sample never reads a stale value
  always @(negedge sclk_q or posedge load) begin
    if (load)
      sh_q <= tx_byte;
    else
      sh_q <= {sh_q[6:0], ~sh_q[0]}; // msb leaves first
  end
  assign serial_in = sh_q[7];
endmodule

// ==== tb/tb.sv ====
// testbench: register accesses and serial frames against the peer model
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic pready, pslverr, serial_in, sclk_q, pin_o, pin_oe, irq, err_q;
  logic port_out = 1, port_oe = 1, load = 1;
  logic [7:0] mosi_q;
  logic [7:0] mosi_n_q;
  int miscompares = 0, compares = 0, edges = 0;
  time t0, t1;
  // ----
  // clock, design and peer
  // ----
  initial forever #50 pclk = ~pclk;
  ssp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .serial_in, .sclk_q, .shared_port_pin_o(pin_o),
    .shared_port_pin_oe(pin_oe), .port_out, .port_oe, .irq);
  ssp_peer peer (.sclk_q, .load, .tx_byte(8'h3c), .serial_in);
  // collect the outgoing bits and edge times at each rising shift clock
  always @(posedge sclk_q) begin
    mosi_q = {mosi_q[6:0], pin_o};
    edges++;
    t0 = t1;
    t1 = $time;
  end
  // phase one drives on the rising edge, so collect its bits at the falling edge
  always @(negedge sclk_q) begin
    mosi_n_q = {mosi_n_q[6:0], pin_o};
  end
  // ----
  // bus and wait tasks
  // ----
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      stop_test();
    end
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // polls are bounded so a frame that never ends cannot hang the run
  task automatic wait_irq();
    for (int n = 0; n < 5000 && irq !== 1'b1; n++) @(posedge pclk);
    if (irq !== 1'b1) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----
  // test sequence
  // ----
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    load <= 1'b0;
    @(posedge pclk);
    `CHK("pin port", 2'b11, {pin_o, pin_oe})
    apb(0, 8'h04, 8'h00);
    `CHK("div reset", 32'h0000_0000, r)
    apb(0, 8'h40, 8'h00);
    `CHK("unmapped", 33'h1_0000_0000, {err_q, r})
    apb(1, 8'h14, 8'h03);
    // every divider code, two-bit frames, input off
    for (int c = 0; c < 8; c++) begin
      apb(1, 8'h00, 8'hff);
      apb(1, 8'h04, {5'b1_0010, c[2:0]});
      edges = 0;
      apb(1, 8'h08, 8'h03);
      wait_irq();
      apb(0, 8'h00, 8'h00);
      `CHK("zero fill", 32'h0000_00fc, r)
      `CHK("edges", 2, edges)
      `CHK("period", (c == 7 ? 256 : 1 << c) * 200, t1 - t0)
      apb(0, 8'h04, 8'h00);
      `CHK("div done", {24'h00_0000, 5'b1_0010, c[2:0]}, r)
      apb(1, 8'h18, 8'h03);
      `CHK("irq low", 1'b0, irq)
    end
    // byte frame with writes during the run
    apb(1, 8'h0c, 8'h01);
    `CHK("pin enable", 1'b1, pin_oe)
    apb(1, 8'h00, 8'ha5);
    apb(1, 8'h04, 8'hc3); // eight bits per frame
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    apb(1, 8'h08, 8'h13);
    apb(1, 8'h04, 8'h00);
    apb(1, 8'h00, 8'hff);
    wait_irq();
    apb(0, 8'h00, 8'h00);
    `CHK("rx data", 32'h0000_003c, r)
    `CHK("tx data", 8'ha5, mosi_q)
    apb(0, 8'h04, 8'h00);
    `CHK("div kept", 32'h0000_00c3, r)
    apb(0, 8'h08, 8'h00);
    `CHK("mode", 32'h0000_0012, r)
    apb(1, 8'h04, 8'hc3);
    apb(0, 8'h04, 8'h00);
    `CHK("done clear", 32'h0000_0043, r)
    apb(1, 8'h04, 8'h80);
    apb(0, 8'h04, 8'h00);
    `CHK("done no set", 32'h0000_0000, r)
    // abort a slow frame part way
    apb(1, 8'h18, 8'h03);
    apb(1, 8'h04, 8'h47);
    apb(1, 8'h08, 8'h03);
    repeat (20) @(posedge pclk);
    apb(1, 8'h08, 8'h02);
    apb(0, 8'h10, 8'h00);
    `CHK("abort irq", 9'h102, {irq, r[7:0]})
    apb(0, 8'h04, 8'h00);
    `CHK("abort div", 32'h0000_0047, r)
    // phase one frame: drive on leading edge, sample on trailing edge
    apb(1, 8'h18, 8'h03);
    apb(1, 8'h00, 8'ha5);
    apb(1, 8'h04, 8'hc3);
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    apb(1, 8'h08, 8'h17);
    wait_irq();
    apb(0, 8'h00, 8'h00);
    `CHK("rx phase one", 32'h0000_003c, r)
    `CHK("tx phase one", 8'ha5, mosi_n_q)
    stop_test();
  end
endmodule

// ==== verilog/ssp_defs.vh ====
// register map, field positions, reset values and timing counts of the serial port
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

// byte addresses on the register bus
`define SSP_ADDR_DATA 8'h00
`define SSP_ADDR_DIV 8'h04
`define SSP_ADDR_MODE 8'h08
`define SSP_ADDR_MISC 8'h0c
`define SSP_ADDR_IRQ_STAT 8'h10
`define SSP_ADDR_IRQ_EN 8'h14
`define SSP_ADDR_IRQ_CLR 8'h18

// divide register fields
`define SSP_DIV_DONE 7
`define SSP_DIV_LEN_HI 6
`define SSP_DIV_LEN_LO 3
`define SSP_DIV_CD_HI 2
`define SSP_DIV_CD_LO 0

// mode register fields
`define SSP_MODE_ACTIVE 0
`define SSP_MODE_IRQ_EN 1
`define SSP_MODE_CLOCK_PHASE_SEL 2
`define SSP_MODE_CLOCK_POLARITY_SEL 3
`define SSP_MODE_IN_EN 4
`define SSP_MODE_EXT_START 5

// misc register fields
`define SSP_MISC_OUT_SEL 0

// reset values
`define SSP_RST_DIV 8'h00
`define SSP_RST_MODE 8'h00
`define SSP_RST_MISC 8'h00

// core clock period in ns and minimum shift-clock half period
`define SSP_CLK_NS 100
`define SSP_MIN_HALF_NS 100
`define SSP_MIN_HALF_CYC ((`SSP_MIN_HALF_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)

`endif

// ==== verilog/ssp_rate_gen.v ====
// bit clock divider: emits a tick each half shift-clock period
`timescale 1ns/10ps
`include "ssp_defs.vh"
module ssp_rate_gen (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire [2:0] code,
  output reg tick_q
);
  reg [7:0] cnt_q;
  wire [7:0] limit;

  // divide ratio per code; one half period is ratio core cycles
  function [7:0] ratio_m1;
    input [2:0] c;
    begin
      case (c)
        3'h7: ratio_m1 = 8'hff;
        default: ratio_m1 = (8'h01 << c) - 8'h01;
      endcase
    end
  endfunction

  assign limit = ratio_m1(code);

  // counter restarts whenever the shifter is idle so each frame starts aligned
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (cnt_q == limit) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end
endmodule

// ==== verilog/ssp_sync.v ====
// three-stage synchroniser for a pin input, change accepted when last two agree
`timescale 1ns/10ps
module ssp_sync (
  input wire pclk,
  input wire presetn,
  input wire pin_in,
  output reg level_q
);
  reg [2:0] sync_q;

  // first stage only feeds the second; second and third vote
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], pin_in};
      if (sync_q[1] == sync_q[2]) begin
        level_q <= sync_q[2];
      end
    end
  end
endmodule

// ==== verilog/ssp_top.v ====
// serial peripheral port: apb registers, master shifter, irq and pin mux
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "ssp_defs.vh"
module ssp_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire serial_in,
  output reg sclk_q,
  output wire shared_port_pin_o,
  output wire shared_port_pin_oe,
  input wire port_out,
  input wire port_oe,
  output wire irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_SHIFT = 3'b100;

  reg [2:0] state_q;
  reg [7:0] div_q;
  reg [7:0] mode_q;
  reg [7:0] misc_q;
  reg [7:0] data_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_en_q;
  reg sout_q;
  reg [3:0] bits_q;
  reg phase_q;
  reg serial_in_d1_q;
  wire sin_lvl;
  wire tick;
  wire wr;
  wire rd_err;
  wire active;
  wire done_evt;
  wire abort_evt;
  wire lead_edge;
  wire trail_edge;
  wire shift_in_bit;
  wire last_bit;

  assign active = mode_q[`SSP_MODE_ACTIVE];
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign rd_err = 1'b0;
  assign pslverr = psel & penable & !(paddr == `SSP_ADDR_DATA || paddr == `SSP_ADDR_DIV
    || paddr == `SSP_ADDR_MODE || paddr == `SSP_ADDR_MISC
    || paddr == `SSP_ADDR_IRQ_STAT || paddr == `SSP_ADDR_IRQ_EN
    || paddr == `SSP_ADDR_IRQ_CLR) | rd_err;

  // ----------------------------------------------------------------
  // pin input and bit clock
  // ----------------------------------------------------------------
  ssp_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(serial_in),
    .level_q(sin_lvl)
  );

  ssp_rate_gen u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .run(state_q == ST_SHIFT),
    .code(div_q[`SSP_DIV_CD_HI:`SSP_DIV_CD_LO]),
    .tick_q(tick)
  );

  // phase_q 0: next tick is the leading edge of a bit, 1: trailing edge
  assign lead_edge = (state_q == ST_SHIFT) & tick & !phase_q;
  assign trail_edge = (state_q == ST_SHIFT) & tick & phase_q;
  // zeros when input disabled
  assign shift_in_bit = mode_q[`SSP_MODE_IN_EN] ? sin_lvl : 1'b0;
  assign last_bit = (bits_q == div_q[`SSP_DIV_LEN_HI:`SSP_DIV_LEN_LO]);
  assign done_evt = trail_edge & last_bit;
  // software dropping the active flag mid-frame aborts it
  assign abort_evt = wr & (paddr == `SSP_ADDR_MODE) & active
    & !pwdata[`SSP_MODE_ACTIVE] & (state_q != ST_IDLE);

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  // clock_phase_sel 0 samples on the leading edge, clock_phase_sel 1 on the trailing edge;
  // clock_polarity_sel only inverts the idle level of the clock pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      bits_q <= 4'h0;
      phase_q <= 1'b0;
      sclk_q <= 1'b0;
      sout_q <= 1'b0;
      serial_in_d1_q <= 1'b0;
    end else begin
      serial_in_d1_q <= sin_lvl;
      case (state_q)
        ST_IDLE: begin
          sclk_q <= mode_q[`SSP_MODE_CLOCK_POLARITY_SEL];
          if (active) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!active) begin
            state_q <= ST_IDLE;
          end else if (!mode_q[`SSP_MODE_EXT_START] || sin_lvl) begin
            state_q <= ST_SHIFT;
            bits_q <= 4'h1;
            phase_q <= 1'b0;
            // clock_phase_sel 0: msb presented as soon as the frame starts
            if (!mode_q[`SSP_MODE_CLOCK_PHASE_SEL]) begin
              sout_q <= data_q[7];
            end
          end
        end
        ST_SHIFT: begin
          if (abort_evt) begin
            state_q <= ST_IDLE;
            sclk_q <= mode_q[`SSP_MODE_CLOCK_POLARITY_SEL];
          end else if (tick) begin
            sclk_q <= ~sclk_q;
            phase_q <= ~phase_q;
            // clock_phase_sel 1 drives the next bit on the leading edge of each period
            if (lead_edge && mode_q[`SSP_MODE_CLOCK_PHASE_SEL]) begin
              sout_q <= data_q[7];
            end
            if (trail_edge) begin
              if (last_bit) begin
                state_q <= ST_IDLE;
              end else begin
                bits_q <= bits_q + 4'h1;
                // the leading edge already shifted, so the next bit sits at the top
                if (!mode_q[`SSP_MODE_CLOCK_PHASE_SEL]) begin
                  sout_q <= data_q[7];
                end
              end
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // data register: software load when idle, msb-first shift during a frame;
  // sample point is leading edge (clock_phase_sel 0) or trailing edge (clock_phase_sel 1)
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= 8'h00;
    end else if (state_q == ST_SHIFT && tick && (phase_q == mode_q[`SSP_MODE_CLOCK_PHASE_SEL])) begin
      data_q <= {data_q[6:0], shift_in_bit};
    end else if (wr && paddr == `SSP_ADDR_DATA && !active) begin
      data_q <= pwdata[7:0];
    end
  end

  // divide register: fields writable only when idle, done flag set wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= `SSP_RST_DIV;
    end else begin
      if (wr && paddr == `SSP_ADDR_DIV && !active) begin
        div_q[6:0] <= pwdata[6:0];
      end
      // a write of one to the done bit clears it; software cannot set it
      if (done_evt) begin
        div_q[`SSP_DIV_DONE] <= 1'b1;
      end else if (wr && paddr == `SSP_ADDR_DIV && pwdata[`SSP_DIV_DONE]) begin
        div_q[`SSP_DIV_DONE] <= 1'b0;
      end
    end
  end

  // mode register: active flag self-clears when the frame ends
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `SSP_RST_MODE;
    end else if (done_evt) begin
      mode_q[`SSP_MODE_ACTIVE] <= 1'b0;
    end else if (wr && paddr == `SSP_ADDR_MODE) begin
      mode_q <= {2'b00, pwdata[5:0]};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_q <= `SSP_RST_MISC;
    end else if (wr && paddr == `SSP_ADDR_MISC) begin
      misc_q <= {7'h00, pwdata[`SSP_MISC_OUT_SEL]};
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  // bit 0 frame done, bit 1 frame aborted; set beats clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 2'h0;
      irq_en_q <= 2'h0;
    end else begin
      if (wr && paddr == `SSP_ADDR_IRQ_EN) begin
        irq_en_q <= pwdata[1:0];
      end
      irq_stat_q[0] <= done_evt | (irq_stat_q[0]
        & !(wr && paddr == `SSP_ADDR_IRQ_CLR && pwdata[0]));
      irq_stat_q[1] <= abort_evt | (irq_stat_q[1]
        & !(wr && paddr == `SSP_ADDR_IRQ_CLR && pwdata[1]));
    end
  end

  // mode enable bit gates the whole request, as the legacy mask did
  assign irq = mode_q[`SSP_MODE_IRQ_EN] & |(irq_stat_q & irq_en_q);

  // ----------------------------------------------------------------
  // pins and read data
  // ----------------------------------------------------------------
  // serial out takes the pin only when selected, else plain port line
  assign shared_port_pin_o = misc_q[`SSP_MISC_OUT_SEL] ? sout_q : port_out;
  assign shared_port_pin_oe = misc_q[`SSP_MISC_OUT_SEL] ? 1'b1 : port_oe;

  // read data registered in the setup cycle; clear register reads zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SSP_ADDR_DATA: prdata <= {24'h00_0000, data_q};
        `SSP_ADDR_DIV: prdata <= {24'h00_0000, div_q};
        `SSP_ADDR_MODE: prdata <= {24'h00_0000, mode_q};
        `SSP_ADDR_MISC: prdata <= {24'h00_0000, misc_q};
        `SSP_ADDR_IRQ_STAT: prdata <= {30'h0000_0000, irq_stat_q};
        `SSP_ADDR_IRQ_EN: prdata <= {30'h0000_0000, irq_en_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
